// [pkg/cet_pkg.sv]
// Purpose: shared constants for the event/timer/pulse block and its host
// Assumes: mclk at 10 MHz; byte-wide command/data link
// Notes: channel count fixed at two by the sense/mask byte layout
package cet_pkg;
   localparam int CET_CHANNELS = 2;
   // command codes on the command port
   localparam logic [7:0] CMD_INT_MASK = 8'h15;
   localparam logic [7:0] CMD_SENSE = 8'h16;
   localparam logic [7:0] CMD_TIMER_DATA = 8'h17;
   localparam logic [7:0] CMD_TIMER_RUN = 8'h18;
   localparam logic [7:0] CMD_PULSE_WIDTH = 8'h19;
   // bit positions in mask, sense and timer-run bytes
   localparam int BIT_FIRST_CH = 0;
   localparam int BIT_SECOND_CH = 1;
   localparam int BIT_TIMER = 4;
   localparam int BIT_RUN = 0;
   // reset values
   localparam logic [7:0] MASK_RESET = 8'h1F;
   localparam logic [7:0] SENSE_RESET = 8'h00;
   localparam logic [31:0] PERIOD_RESET = 32'h00000000;
   localparam logic [7:0] WIDTH_RESET = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'h00;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIMER_TICK_NS = 50;
   localparam logic [32:0] TICKS_PER_CLK =
      33'(CLK_PERIOD_NS / TIMER_TICK_NS);
   localparam int PULSE_UNIT_NS = 409600;
   localparam int PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [11:0] PULSE_PRE_LAST = 12'(PULSE_UNIT_CYC - 1);
   // host software register offsets, emask reset value and event bits
   localparam logic [3:0] HOST_CMD = 4'h0;
   localparam logic [3:0] HOST_DATA = 4'h1;
   localparam logic [3:0] HOST_FETCH = 4'h2;
   localparam logic [3:0] HOST_RDBYTE = 4'h3;
   localparam logic [3:0] HOST_STAT = 4'h4;
   localparam logic [3:0] HOST_EVT = 4'h5;
   localparam logic [3:0] HOST_EMASK = 4'h6;
   localparam logic [1:0] HOST_EMASK_RESET = 2'h3;
   localparam int EVT_FETCH = 0;
   localparam int EVT_DEVIRQ = 1;
endpackage

// [pkg/cet_if.sv]
`timescale 1ns/100ps
// Purpose: byte link between host controller and event/timer block
// Assumes: both ends clocked by the same mclk
// Notes: cmdWr is the command port, dataWr/dataRd the data port
interface cet_if;
   logic cmdWr;
   logic dataWr;
   logic dataRd;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic devIrq;
   modport dev(input cmdWr, input dataWr, input dataRd, input wrData,
      output rdData, output devIrq);
   modport host(output cmdWr, output dataWr, output dataRd,
      output wrData, input rdData, input devIrq);
endinterface

// [design/cet_host.sv]
`timescale 1ns/100ps
// Purpose: host end, turns software register accesses into link strobes
// Assumes: software orders commands before their data bytes
// Notes: one link strobe per software write to HOST_CMD, HOST_DATA or HOST_FETCH, one cycle later
module cet_host
   import cet_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   cet_if.host link,
   input wire logic [3:0] swAddr,
   input wire logic [7:0] swWdata,
   input wire logic swWr,
   input wire logic swRd,
   output logic [7:0] swRdata,
   output logic irq
);
   typedef struct packed {
      logic cmdWr;
      logic dataWr;
      logic dataRd;
      logic [7:0] wrData;
      logic fetchWait;
      logic [7:0] rdByte;
      logic [1:0] evt;
      logic [1:0] emask;
      logic irqPrev;
      logic [7:0] swRdata;
      logic irq;
   } cet_hstate_t;

   cet_hstate_t st_ff, nxt_st;

   always_comb begin
      logic [1:0] set;
      logic [1:0] clr;
      set = 2'h0;
      clr = 2'h0;
      nxt_st = st_ff;
      nxt_st.cmdWr = 1'b0;
      nxt_st.dataWr = 1'b0;
      nxt_st.dataRd = 1'b0;
      nxt_st.swRdata = 8'h00;
      nxt_st.fetchWait = st_ff.dataRd;
      nxt_st.irqPrev = link.devIrq;
      // command first, then its data bytes, in software order
      if (swWr) begin
         case (swAddr)
            HOST_CMD: begin
               nxt_st.cmdWr = 1'b1;
               nxt_st.wrData = swWdata;
            end
            HOST_DATA: begin
               nxt_st.dataWr = 1'b1;
               nxt_st.wrData = swWdata;
            end
            HOST_FETCH: nxt_st.dataRd = 1'b1;
            HOST_EVT: clr = swWdata[1:0];
            HOST_EMASK: nxt_st.emask = swWdata[1:0];
            default: ;
         endcase
      end
      if (st_ff.fetchWait) begin
         nxt_st.rdByte = link.rdData;
         set[EVT_FETCH] = 1'b1;
      end
      set[EVT_DEVIRQ] = link.devIrq & ~st_ff.irqPrev;
      // a new event wins over a clear in the same cycle
      nxt_st.evt = (st_ff.evt & ~clr) | set;
      if (swRd) begin
         case (swAddr)
            HOST_RDBYTE: nxt_st.swRdata = st_ff.rdByte;
            HOST_STAT: nxt_st.swRdata = {7'h00, link.devIrq};
            HOST_EVT: nxt_st.swRdata = {6'h00, st_ff.evt};
            HOST_EMASK: nxt_st.swRdata = {6'h00, st_ff.emask};
            default: nxt_st.swRdata = 8'h00;
         endcase
      end
      nxt_st.irq = |(nxt_st.evt & ~nxt_st.emask);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.emask <= HOST_EMASK_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.cmdWr = st_ff.cmdWr;
   assign link.dataWr = st_ff.dataWr;
   assign link.dataRd = st_ff.dataRd;
   assign link.wrData = st_ff.wrData;
   assign swRdata = st_ff.swRdata;
   assign irq = st_ff.irq;
endmodule

// [design/cet_device.sv]
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
// Purpose: interrupt mask/sense, interval timer and one-shot pulses
// Assumes: compareEq is a level from the counting logic, high on match
// Notes: counting, filtering and latching live outside this block;
//        out-of-range tiny periods give at most one expiry per clock
module cet_device
   import cet_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   cet_if.dev link,
   input wire logic [CET_CHANNELS-1:0] compareEq,
   output logic [CET_CHANNELS-1:0] pulseOut,
   output logic timerExpired
);
   typedef struct packed {
      logic [7:0] cmd;
      logic [1:0] byteIdx;
      logic [7:0] mask;
      logic [2:0] sense;
      logic [31:0] period;
      logic run;
      logic [32:0] acc;
      logic [7:0] width;
      logic [CET_CHANNELS-1:0] eqPrev;
      logic [CET_CHANNELS-1:0][11:0] pre;
      logic [CET_CHANNELS-1:0][7:0] left;
      logic [CET_CHANNELS-1:0] pulse;
      logic expired;
      logic [7:0] rdData;
      logic irq;
   } cet_dstate_t;

   // sense bits kept as {timer, second channel, first channel}
   function automatic logic [7:0] to_byte(input logic [2:0] s);
      logic [7:0] b;
      b = 8'h00;
      b[BIT_TIMER] = s[2];
      b[BIT_SECOND_CH] = s[1];
      b[BIT_FIRST_CH] = s[0];
      return b;
   endfunction

   function automatic logic [2:0] from_byte(input logic [7:0] b);
      return {b[BIT_TIMER], b[BIT_SECOND_CH], b[BIT_FIRST_CH]};
   endfunction

   // one interval-timer clock: {expiry, next accumulator}
   function automatic logic [33:0] timer_step(
         input logic running,
         input logic [32:0] acc,
         input logic [31:0] period);
      logic [32:0] lim;
      logic [32:0] sum;
      logic [32:0] rem;
      logic [33:0] r;
      lim = {1'b0, period} + 33'h1;
      sum = acc + TICKS_PER_CLK;
      rem = sum - lim;
      r = {1'b0, sum};
      if (!running) begin
         // stopping drops the partial interval, so a restart is whole
         r = {1'b0, 33'h0};
      end else if (sum >= lim) begin
         if (rem >= lim) begin
            // out-of-range tiny periods would outrun one expiry per clock
            r = {1'b1, 33'h0};
         end else begin
            r = {1'b1, rem};
         end
      end
      return r;
   endfunction

   // one clock of a channel's one-shot: {pulse, units left, prescale}
   function automatic logic [20:0] pulse_step(
         input logic start,
         input logic [7:0] width,
         input logic active,
         input logic [7:0] left,
         input logic [11:0] pre);
      logic [20:0] r;
      r = {active, left, pre};
      if (start && width != 8'h00) begin
         // a match during a pulse restarts it at full width
         r = {1'b1, width, 12'h000};
      end else if (active) begin
         // one width unit is PULSE_UNIT_CYC clocks
         if (pre == PULSE_PRE_LAST) begin
            r = {left != 8'h01, left - 8'h01, 12'h000};
         end else begin
            r = {1'b1, left, pre + 12'h001};
         end
      end
      return r;
   endfunction

   // what a data-port read returns for the command in force
   function automatic logic [7:0] read_byte(
         input logic [7:0] cmd,
         input logic [7:0] mask,
         input logic [2:0] sense);
      logic [7:0] b;
      b = 8'h00;
      case (cmd)
         CMD_INT_MASK: begin
            b = mask;
         end
         CMD_SENSE: begin
            b = to_byte(sense);
         end
         default: begin
            // write-only settings read back as zero
            b = 8'h00;
         end
      endcase
      return b;
   endfunction

   cet_dstate_t st_ff, nxt_st;

   always_comb begin
      logic [2:0] ev;
      logic [2:0] clr;
      logic [CET_CHANNELS-1:0] eqRise;
      logic [33:0] tStep;
      logic [20:0] pStep;
      ev = 3'h0;
      clr = 3'h0;
      eqRise = compareEq & ~st_ff.eqPrev;
      tStep = timer_step(st_ff.run, st_ff.acc, st_ff.period);
      pStep = 21'h0;
      nxt_st = st_ff;
      nxt_st.eqPrev = compareEq;
      nxt_st.expired = 1'b0;
      nxt_st.rdData = 8'h00;

      // command port selects what the data port means
      if (link.cmdWr) begin
         nxt_st.cmd = link.wrData;
         nxt_st.byteIdx = 2'h0;
      end else if (link.dataWr) begin
         case (st_ff.cmd)
            CMD_INT_MASK: begin
               // full byte kept for read-back; only D4, D1, D0 act
               nxt_st.mask = link.wrData;
            end
            CMD_SENSE: begin
               // ones clear; a set in the same clock still wins
               clr = from_byte(link.wrData);
            end
            CMD_TIMER_DATA: begin
               // bytes arrive low first
               nxt_st.period[8*st_ff.byteIdx +: 8] = link.wrData;
               nxt_st.byteIdx = st_ff.byteIdx + 2'h1;
            end
            CMD_TIMER_RUN: begin
               nxt_st.run = link.wrData[BIT_RUN];
            end
            CMD_PULSE_WIDTH: begin
               nxt_st.width = link.wrData;
            end
            default: begin
               // bytes for other commands belong to the counting logic
            end
         endcase
      end else if (link.dataRd) begin
         nxt_st.rdData = read_byte(st_ff.cmd, st_ff.mask, st_ff.sense);
      end

      // 50 ns ticks accumulate two per clock; remainder carries over
      ev[2] = tStep[33];
      nxt_st.expired = tStep[33];
      nxt_st.acc = tStep[32:0];

      for (int c = 0; c < CET_CHANNELS; c++) begin
         ev[c] = eqRise[c];
         // each channel pulses on its own match
         pStep = pulse_step(eqRise[c], st_ff.width, st_ff.pulse[c],
            st_ff.left[c], st_ff.pre[c]);
         nxt_st.pulse[c] = pStep[20];
         nxt_st.left[c] = pStep[19:12];
         nxt_st.pre[c] = pStep[11:0];
      end

      // events recorded whatever the mask; set beats clear
      nxt_st.sense = (st_ff.sense & ~clr) | ev;
      // level stays high while set, so repeats add nothing
      nxt_st.irq = |(nxt_st.sense & ~from_byte(nxt_st.mask));
      // timer source gated by mask D4
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.cmd <= CMD_RESET;
         st_ff.mask <= MASK_RESET;
         st_ff.sense <= SENSE_RESET[2:0];
         st_ff.period <= PERIOD_RESET;
         st_ff.run <= 1'b0;
         st_ff.width <= WIDTH_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.rdData = st_ff.rdData;
   assign link.devIrq = st_ff.irq;
   assign pulseOut = st_ff.pulse;
   assign timerExpired = st_ff.expired;
endmodule

// [bench/cet_properties.sv]
`timescale 1ns/100ps
// Purpose: link-level properties of the event/timer block
// Assumes: sees only the byte link between the two ends
// Notes: tracks last command and mask byte from link traffic
module cet_properties
   import cet_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmdWr,
   input wire logic dataWr,
   input wire logic dataRd,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdData,
   input wire logic devIrq
);
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] mask;
      logic clrOrMask;
   } cet_seen_t;
   cet_seen_t seen_ff, nxt_seen;
   logic allMasked;
   assign allMasked = seen_ff.mask[4] & seen_ff.mask[1] & seen_ff.mask[0];
   always_comb begin
      nxt_seen = seen_ff;
      nxt_seen.clrOrMask = dataWr && !cmdWr
         && (seen_ff.cmd == CMD_INT_MASK || seen_ff.cmd == CMD_SENSE);
      if (cmdWr) begin
         nxt_seen.cmd = wrData;
      end else if (dataWr && seen_ff.cmd == CMD_INT_MASK) begin
         nxt_seen.mask = wrData;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seen_ff <= '{CMD_RESET, MASK_RESET, 1'b0};
      end else begin
         seen_ff <= nxt_seen;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   rd_idle_a: assert property (!$past(dataRd) |-> rdData == 8'h00)
      else $error("read byte outside a read slot");
   mask_readback_a: assert property (dataRd && seen_ff.cmd == CMD_INT_MASK
      |=> rdData == seen_ff.mask) else $error("mask read differs");
   sense_layout_a: assert property (dataRd && seen_ff.cmd == CMD_SENSE
      |=> (rdData & 8'hEC) == 8'h00) else $error("unused sense bit set");
   other_read_a: assert property (dataRd && seen_ff.cmd != CMD_INT_MASK
      && seen_ff.cmd != CMD_SENSE |=> rdData == 8'h00)
      else $error("read of write-only command not zero");
   masked_quiet_a: assert property (allMasked && $past(allMasked) |-> !devIrq)
      else $error("interrupt while all sources masked");
   rise_unmasked_a: assert property ($rose(devIrq) |-> !allMasked)
      else $error("interrupt rose with all masked");
   irq_sticky_a: assert property ($fell(devIrq) |-> seen_ff.clrOrMask
      || $past(seen_ff.clrOrMask)) else $error("interrupt dropped unasked");
   one_strobe_a: assert property ($onehot0({cmdWr, dataWr, dataRd}))
      else $error("two link strobes at once");
   cover property ($rose(devIrq));
   cover property ($fell(devIrq));
   cover property (dataRd && seen_ff.cmd == CMD_SENSE);
endmodule

// [bench/tb_counter_event_timer_pulse.sv]
`timescale 1ns/100ps
// Purpose: drives software port of host end against device end
// Assumes: compareEq edges stand in for counting logic matches
// Notes: read bytes and pulse widths checked from queues of notes
module tb_counter_event_timer_pulse
   import cet_pkg::*;
();
   logic mclk = 1'b0, rst_n = 1'b0, swWr = 1'b0, swRd = 1'b0;
   logic [3:0] swAddr = 4'h0;
   logic [7:0] swWdata = 8'h00, swRdata;
   logic [1:0] compareEq = 2'h0, pulseOut;
   logic irq, timerExpired, rdLate = 1'b0;
   int mismatches = 0, totalChecks = 0, run[2] = '{0, 0}, n, g;
   logic [7:0] expQ[$];
   int pulseQ[$];
   cet_if link();
   cet_host i_cet_host(.mclk(mclk), .rst_n(rst_n), .link(link),
      .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd),
      .swRdata(swRdata), .irq(irq));
   cet_device i_cet_device(.mclk(mclk), .rst_n(rst_n), .link(link),
      .compareEq(compareEq), .pulseOut(pulseOut),
      .timerExpired(timerExpired));
   cet_properties i_cet_properties(.mclk(mclk), .rst_n(rst_n),
      .cmdWr(link.cmdWr), .dataWr(link.dataWr), .dataRd(link.dataRd),
      .wrData(link.wrData), .rdData(link.rdData), .devIrq(link.devIrq));
   always #50 mclk = ~mclk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // a read passes its expected byte in d
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      swWr <= w;
      swRd <= !w;
      swAddr <= a;
      swWdata <= d;
      if (!w) expQ.push_back(d);
      @(posedge mclk);
      swWr <= 1'b0;
      swRd <= 1'b0;
   endtask
   // settle time lets the device and host status catch up
   task automatic cmd(input logic [7:0] c, input logic [7:0] d);
      acc(1'b1, HOST_CMD, c);
      acc(1'b1, HOST_DATA, d);
      repeat (4) @(posedge mclk);
   endtask
   task automatic devRd(input logic [7:0] c, input logic [7:0] e);
      acc(1'b1, HOST_CMD, c);
      acc(1'b1, HOST_FETCH, 8'h00);
      repeat (3) @(posedge mclk);
      acc(1'b0, HOST_RDBYTE, e);
   endtask
   task automatic bump(input int c);
      @(posedge mclk);
      compareEq[c] <= 1'b1;
      repeat (3) @(posedge mclk);
      compareEq[c] <= 1'b0;
   endtask
   task automatic waitIrq(input logic v);
      for (int k = 0; k < 20 && irq !== v; k++) @(negedge mclk);
      check({15'h0000, irq}, {15'h0000, v});
   endtask
   // an expiry already in view starts the count, so none is skipped
   task automatic gap(output int k);
      for (k = 0; k < 12000 && timerExpired !== 1'b1; k++) @(negedge mclk);
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (timerExpired !== 1'b1 && k < 12000);
      if (k >= 12000) begin
         mismatches++;
         conclude();
      end
   endtask
   task automatic idle();
      logic a;
      a = 1'b0;
      repeat (30) begin
         @(negedge mclk);
         a = a | timerExpired;
      end
      check({15'h0000, a}, 16'h0000);
   endtask
   always @(posedge mclk) begin
      if (rdLate) check({8'h00, swRdata}, {8'h00, expQ.pop_front()});
      rdLate <= swRd;
   end
   // a pulse with no note waiting must be flagged
   always @(negedge mclk) begin
      for (int c = 0; c < 2; c++) begin
         if (pulseOut[c] === 1'b1) begin
            run[c]++;
         end else if (run[c] != 0) begin
            if (pulseQ.size() == 0) pulseQ.push_back(0);
            check(16'(run[c]), 16'(pulseQ.pop_front()));
            run[c] = 0;
         end
      end
   end
   initial begin
      void'($urandom(32'hA923));
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      devRd(CMD_INT_MASK, MASK_RESET);
      devRd(CMD_SENSE, SENSE_RESET);
      acc(1'b0, HOST_EMASK, {6'h00, HOST_EMASK_RESET});
      acc(1'b0, 4'hF, 8'h00);
      idle();
      bump(0);
      devRd(CMD_SENSE, 8'h01);
      acc(1'b0, HOST_STAT, 8'h00);
      for (int c = 0; c < 2; c++) begin
         bump(c);
         acc(1'b1, HOST_EMASK, 8'h01);
         cmd(CMD_INT_MASK, MASK_RESET & ~(8'h01 << c));
         waitIrq(1'b1);
         acc(1'b1, HOST_EMASK, 8'h03);
         waitIrq(1'b0);
         acc(1'b1, HOST_EVT, 8'h03);
         acc(1'b1, HOST_EMASK, 8'h01);
         bump(c);
         acc(1'b0, HOST_EVT, 8'h00);
         cmd(CMD_SENSE, 8'($urandom) | (8'h01 << c));
         acc(1'b0, HOST_STAT, 8'h00);
         cmd(CMD_INT_MASK, MASK_RESET);
      end
      // odd values just above the 1 ms floor keep each interval whole
      n = 19999 + 2 * ($urandom % 8);
      acc(1'b1, HOST_CMD, CMD_TIMER_DATA);
      for (int b = 0; b < 4; b++) begin
         acc(1'b1, HOST_DATA, 8'(n >> (8 * b)));
      end
      cmd(CMD_TIMER_RUN, 8'h01);
      repeat (3) begin
         gap(g);
         check(16'(g), 16'((n + 1) / 2));
      end
      acc(1'b0, HOST_STAT, 8'h00);
      devRd(CMD_SENSE, 8'h10);
      cmd(CMD_INT_MASK, 8'h0F);
      acc(1'b0, HOST_STAT, 8'h01);
      cmd(CMD_TIMER_RUN, 8'h00);
      idle();
      n = 1 + $urandom % 2;
      cmd(CMD_PULSE_WIDTH, 8'(n));
      for (int c = 0; c < 2; c++) begin
         pulseQ.push_back(PULSE_UNIT_CYC * n);
         bump(c);
         for (g = 0; g < 9000 && pulseQ.size() != 0; g++) @(negedge mclk);
      end
      if (pulseQ.size() != 0) mismatches++;
      conclude();
   end
endmodule
